// *** rtl/vrfp_core.sv ***
// vrfp_core: fault protection, diode-time adaptation and indexed register set
`timescale 1ns/1ps
`default_nettype none
module vrfp_core import vrfp_pkg::*; #(
  parameter int OC_QUAL = OC_QUAL_CYC,
  parameter int IMB_QUAL = IMB_QUAL_CYC,
  parameter logic [7:0] VENDOR_CODE = 8'hA5,   // arbitrary value
  parameter logic [7:0] PRODUCT_CODE = 8'h5A,  // arbitrary value
  parameter logic [7:0] SILICON_REV = 8'h01,   // arbitrary value
  parameter logic RAIL_SECOND = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic regulator_enable_in,
  input wire vrfp_sense_type sense_in,
  input wire logic discontinuous_mode_in,
  input wire logic zero_cross_in,
  input wire logic phase_node_neg_in,
  input wire logic low_side_done_in,
  input wire logic [7:0] strap_imax_in,
  input wire logic [7:0] strap_tmax_in,
  input wire logic [7:0] strap_boot_in,
  input wire logic target_reached_in,
  input wire logic hot_in,
  input wire logic imax_reached_in,
  input wire logic [7:0] tzone_in,
  input wire logic [7:0] secondary_status_in,
  input wire logic reg_write_in,
  input wire logic register_read_command_in,
  input wire logic voltage_set_command_in,
  input wire vrfp_slew_type slew_in,
  input wire logic power_state_write_in,
  input wire logic [7:0] reg_index_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic not_supported_out,
  output logic power_good_out,
  output vrfp_drive_type drive_out,
  output logic low_side_end_out,
  output logic [5:0] zc_threshold_out,
  output logic soft_start_out,
  output logic [7:0] target_code_out,
  output logic alert_n_out
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [11:0] s1_r;
  logic [11:0] s2_r;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s1_r <= 12'h000;
      s2_r <= 12'h000;
    end else begin
      s1_r <= {regulator_enable_in, sense_in, discontinuous_mode_in, zero_cross_in,
               phase_node_neg_in, low_side_done_in, target_reached_in, hot_in};
      s2_r <= s1_r;
    end
  end
  logic en_s;
  logic oc_s;
  logic woc_s;
  logic imb_s;
  logic ov_s;
  logic below_s;
  logic dcm_s;
  logic zc_s;
  logic neg_s;
  logic lsd_s;
  logic reach_s;
  logic hot_s;
  assign {en_s, oc_s, woc_s, imb_s, ov_s, below_s, dcm_s, zc_s, neg_s, lsd_s, reach_s,
          hot_s} = s2_r;

  logic imax_s1_r;
  logic imax_s2_r;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      imax_s1_r <= 1'b0;
      imax_s2_r <= 1'b0;
    end else begin
      imax_s1_r <= imax_reached_in;
      imax_s2_r <= imax_s1_r;
    end
  end

  // enable low acts as reset on the fault logic
  logic clr;
  assign clr = rst_in | ~en_s;

  // ---------------------------------------------------------------
  // qualification timers
  // ---------------------------------------------------------------
  function automatic logic [QCNT_W-1:0] qual_next(input logic cond,
                                                  input logic [QCNT_W-1:0] cnt);
    qual_next = cond ? cnt + 24'h000001 : 24'h000000;
  endfunction

  logic [QCNT_W-1:0] oc_cnt_r;
  logic [QCNT_W-1:0] imb_cnt_r;
  always_ff @(posedge core_clk_in) begin
    if (clr) begin
      oc_cnt_r <= 24'h000000;
      imb_cnt_r <= 24'h000000;
    end else begin
      oc_cnt_r <= qual_next(oc_s, oc_cnt_r);
      imb_cnt_r <= qual_next(imb_s, imb_cnt_r);
    end
  end

  logic oc_fault_r;
  logic woc_fault_r;
  logic imb_fault_r;
  always_ff @(posedge core_clk_in) begin
    if (clr) begin
      oc_fault_r <= 1'b0;
      woc_fault_r <= 1'b0;
      imb_fault_r <= 1'b0;
    end else begin
      if (oc_s && oc_cnt_r >= QCNT_W'(OC_QUAL - 1)) oc_fault_r <= 1'b1;
      if (woc_s) woc_fault_r <= 1'b1;
      if (imb_s && imb_cnt_r >= QCNT_W'(IMB_QUAL - 1)) imb_fault_r <= 1'b1;
    end
  end
  logic shut_fault;
  assign shut_fault = oc_fault_r | woc_fault_r | imb_fault_r;

  // ---------------------------------------------------------------
  // overvoltage pull-down sequence
  // ---------------------------------------------------------------
  vrfp_ov_state_type ov_r;
  always_ff @(posedge core_clk_in) begin
    if (clr) begin
      ov_r <= VRFP_OV_IDLE;
    end else begin
      unique case (ov_r)
        VRFP_OV_IDLE: begin
          if (ov_s) ov_r <= VRFP_OV_PULL;
        end
        VRFP_OV_PULL: begin
          if (below_s) ov_r <= VRFP_OV_OFF;
        end
        VRFP_OV_OFF: begin
          if (ov_s) ov_r <= VRFP_OV_PULL;
        end
        default: ov_r <= VRFP_OV_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // drive and power-good outputs
  // ---------------------------------------------------------------
  logic fault_any;
  assign fault_any = shut_fault | (ov_r != VRFP_OV_IDLE) | ov_s | woc_s;
  always_ff @(posedge core_clk_in) begin
    if (clr) begin
      power_good_out <= 1'b0;
      drive_out <= '{high_on: 1'b0, low_on: 1'b0, tristate: 1'b1};
    end else begin
      power_good_out <= ~fault_any;
      if (ov_s || ov_r == VRFP_OV_PULL) begin
        drive_out <= '{high_on: 1'b0, low_on: 1'b1, tristate: 1'b0};
      end else if (shut_fault || woc_s || ov_r == VRFP_OV_OFF) begin
        drive_out <= '{high_on: 1'b0, low_on: 1'b0, tristate: 1'b1};
      end else begin
        drive_out <= '{high_on: 1'b0, low_on: 1'b0, tristate: 1'b0};
      end
    end
  end

  // soft-start request pulses on the first enabled cycle after clearing
  logic en_seen_r;
  always_ff @(posedge core_clk_in) begin
    if (clr) begin
      en_seen_r <= 1'b0;
      soft_start_out <= 1'b0;
    end else begin
      en_seen_r <= 1'b1;
      soft_start_out <= ~en_seen_r;
    end
  end

  // ---------------------------------------------------------------
  // discontinuous-mode low-side end and threshold adaptation
  // ---------------------------------------------------------------
  logic [7:0] diode_cnt_r;
  logic measuring_r;
  always_ff @(posedge core_clk_in) begin
    if (clr) begin
      low_side_end_out <= 1'b0;
    end else begin
      low_side_end_out <= dcm_s & zc_s;
    end
  end

  // measure how long the phase node stays negative after turn-off
  always_ff @(posedge core_clk_in) begin
    if (clr) begin
      measuring_r <= 1'b0;
      diode_cnt_r <= 8'h00;
      zc_threshold_out <= ZC_THR_RST;
    end else if (lsd_s && dcm_s) begin
      measuring_r <= 1'b1;
      diode_cnt_r <= 8'h00;
    end else if (measuring_r && neg_s) begin
      if (diode_cnt_r != 8'hFF) diode_cnt_r <= diode_cnt_r + 8'h01;
    end else if (measuring_r) begin
      measuring_r <= 1'b0;
      // one step per measurement keeps the loop stable against noisy edges
      if (diode_cnt_r > 8'(DIODE_TARGET_CYC) && zc_threshold_out != 6'h3F) begin
        zc_threshold_out <= zc_threshold_out + 6'h01;
      end else if (diode_cnt_r < 8'(DIODE_TARGET_CYC) && zc_threshold_out != 6'h00) begin
        zc_threshold_out <= zc_threshold_out - 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // strapped and master-written registers
  // ---------------------------------------------------------------
  logic [7:0] imax_r;
  logic [7:0] tmax_r;
  logic [7:0] boot_r;
  logic straps_taken_r;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      imax_r <= ZERO8;
      tmax_r <= ZERO8;
      boot_r <= ZERO8;
      straps_taken_r <= 1'b0;
    end else if (!straps_taken_r) begin
      imax_r <= strap_imax_in;
      tmax_r <= strap_tmax_in;
      boot_r <= strap_boot_in;
      straps_taken_r <= 1'b1;
    end
  end

  logic [7:0] vmax_r;
  logic [7:0] margin_r;
  logic [7:0] multi_r;
  logic wr_ok;
  assign wr_ok = reg_write_in & ~voltage_set_command_in;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      vmax_r <= VMAX_RST;
      margin_r <= ZERO8;
      multi_r <= RAIL_SECOND ? MULTI_RST_R2 : MULTI_RST_R1;
    end else if (wr_ok) begin
      if (reg_index_in == REG_VMAX) vmax_r <= reg_wdata_in;
      if (reg_index_in == REG_MARGIN) margin_r <= reg_wdata_in;
      if (reg_index_in == REG_MULTI) multi_r <= reg_wdata_in;
    end
  end

  // ---------------------------------------------------------------
  // voltage code, power state, margin
  // ---------------------------------------------------------------
  logic [7:0] vset_r;
  logic [7:0] pstate_r;
  logic cmd_seen_r;
  vrfp_slew_type slew_r;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      vset_r <= ZERO8;
      pstate_r <= ZERO8;
      cmd_seen_r <= 1'b0;
      not_supported_out <= 1'b0;
      slew_r <= VRFP_SLEW_NONE;
    end else begin
      not_supported_out <= 1'b0;
      if (voltage_set_command_in) begin
        if (reg_wdata_in > vmax_r) begin
          not_supported_out <= 1'b1;
        end else begin
          vset_r <= reg_wdata_in;
          cmd_seen_r <= 1'b1;
          slew_r <= slew_in;
        end
      end else if (reach_s) begin
        slew_r <= VRFP_SLEW_NONE;
      end
      if (power_state_write_in) pstate_r <= reg_wdata_in;
    end
  end

  logic [7:0] base_code;
  logic [8:0] sum_code;
  assign base_code = cmd_seen_r ? vset_r : boot_r;
  always_comb begin
    if (margin_r[MARGIN_SIGN_BIT]) begin
      sum_code = {1'b0, base_code} - {2'b00, margin_r[6:0]};
    end else begin
      sum_code = {1'b0, base_code} + {2'b00, margin_r[6:0]};
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      target_code_out <= ZERO8;
    end else if (sum_code[8]) begin
      target_code_out <= margin_r[MARGIN_SIGN_BIT] ? 8'h00 : 8'hFF;
    end else begin
      target_code_out <= sum_code[7:0];
    end
  end

  // ---------------------------------------------------------------
  // status and alert
  // ---------------------------------------------------------------
  logic [7:0] stat1_r;
  logic [7:0] shadow_r;
  logic stat1_read;
  assign stat1_read = register_read_command_in & (reg_index_in == REG_STAT1);
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stat1_r <= ZERO8;
    end else begin
      stat1_r <= ZERO8;
      stat1_r[STAT1_SETTLED_BIT] <= reach_s;
      stat1_r[STAT1_HOT_BIT] <= hot_s;
      stat1_r[STAT1_IMAX_BIT] <= imax_s2_r;
    end
  end

  // alert held low until the master reads primary status; a new arrival wins
  logic fast_or_slow;
  assign fast_or_slow = (slew_r == VRFP_SLEW_FAST) | (slew_r == VRFP_SLEW_SLOW);
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      alert_n_out <= 1'b1;
    end else if (reach_s && fast_or_slow) begin
      alert_n_out <= 1'b0;
    end else if (stat1_read) begin
      alert_n_out <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      shadow_r <= ZERO8;
    end else if (register_read_command_in && reg_index_in == REG_STAT2) begin
      shadow_r <= secondary_status_in;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= ZERO8;
    end else if (register_read_command_in) begin
      unique case (reg_index_in)
        REG_VENDOR: reg_rdata_out <= VENDOR_CODE;
        REG_PRODUCT: reg_rdata_out <= PRODUCT_CODE;
        REG_SIREV: reg_rdata_out <= SILICON_REV;
        REG_PROTO: reg_rdata_out <= PROTO_VAL;
        REG_CAPS: reg_rdata_out <= CAPS_VAL;
        REG_STAT1: reg_rdata_out <= stat1_r;
        REG_STAT2: reg_rdata_out <= secondary_status_in;
        REG_TZONE: reg_rdata_out <= tzone_in;
        REG_STAT2_SHADOW: reg_rdata_out <= shadow_r;
        REG_IMAX: reg_rdata_out <= imax_r;
        REG_TMAX: reg_rdata_out <= tmax_r;
        REG_FAST_SLEW_RATE: reg_rdata_out <= FAST_SLEW_RATE_VAL;
        REG_SLOW_SLEW_RATE: reg_rdata_out <= SLOW_SLEW_RATE_VAL;
        REG_BOOT: reg_rdata_out <= boot_r;
        REG_VMAX: reg_rdata_out <= vmax_r;
        REG_VSET: reg_rdata_out <= vset_r;
        REG_PSTATE: reg_rdata_out <= pstate_r;
        REG_MARGIN: reg_rdata_out <= margin_r;
        REG_MULTI: reg_rdata_out <= multi_r;
        default: reg_rdata_out <= ZERO8;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/vrfp_pkg.sv ***
// vrfp_pkg: constants and types for the regulator fault-protection and register block
// Notes on behaviour
// - overcurrent flagged only after droop current stays above threshold for 120 us
// - current above 1.5x overcurrent level disables drives and power-good at once; code holds low-sides on during an overvoltage pull-down
// - phase current-sense difference above limit for 1 ms latches imbalance fault
// - overcurrent, short and imbalance faults drop power-good and tri-state all drives; code holds low-sides on during an overvoltage pull-down
// - output above commanded voltage plus margin flags overvoltage, low-sides turn on
// - low-sides stay on until output falls below commanded voltage, then all off
// - overvoltage recurring after drives off repeats the low-side pull-down
// - faults clear only by enable low or power-on reset; then soft-start
// - discontinuous mode ends low-side on-period at the zero-crossing comparator
// - after low-side turn-off, step comparator threshold toward 40 ns diode conduction
// - protocol revision register at 05h reads 01h
// - capability register at 06h reads 81h
// - primary status at 10h shows settled, hot and max-current; read after alert
// - reading secondary status copies the value into the shadow register
// - max-current register loaded at start-up from resistor straps, in amperes
// - max-temperature register loaded at start-up from resistor strap, in degrees
// - fast slew rate at 24h defaults 0Ah, slow rate at 25h defaults 02h
// - boot voltage is the target at start-up until a voltage-set command arrives
// - voltage codes above the writable maximum (default FBh) answer not-supported
// - programmed voltage code at 31h and power state at 32h, both reset zero
// - multi-rail config per rail, first defaults 00h, second 01h
// - active-low alert asserts when a fast or slow transition reaches target
package vrfp_pkg;
  localparam logic [7:0] REG_VENDOR = 8'h00;
  localparam logic [7:0] REG_PRODUCT = 8'h01;
  localparam logic [7:0] REG_SIREV = 8'h02;
  localparam logic [7:0] REG_PROTO = 8'h05;
  localparam logic [7:0] REG_CAPS = 8'h06;
  localparam logic [7:0] REG_STAT1 = 8'h10;
  localparam logic [7:0] REG_STAT2 = 8'h11;
  localparam logic [7:0] REG_TZONE = 8'h12;
  localparam logic [7:0] REG_STAT2_SHADOW = 8'h1C;
  localparam logic [7:0] REG_IMAX = 8'h21;
  localparam logic [7:0] REG_TMAX = 8'h22;
  localparam logic [7:0] REG_FAST_SLEW_RATE = 8'h24;
  localparam logic [7:0] REG_SLOW_SLEW_RATE = 8'h25;
  localparam logic [7:0] REG_BOOT = 8'h26;
  localparam logic [7:0] REG_VMAX = 8'h30;
  localparam logic [7:0] REG_VSET = 8'h31;
  localparam logic [7:0] REG_PSTATE = 8'h32;
  localparam logic [7:0] REG_MARGIN = 8'h33;
  localparam logic [7:0] REG_MULTI = 8'h34;

  localparam logic [7:0] PROTO_VAL = 8'h01;
  localparam logic [7:0] CAPS_VAL = 8'h81;
  localparam logic [7:0] FAST_SLEW_RATE_VAL = 8'h0A;
  localparam logic [7:0] SLOW_SLEW_RATE_VAL = 8'h02;
  localparam logic [7:0] VMAX_RST = 8'hFB;
  localparam logic [7:0] MULTI_RST_R1 = 8'h00;
  localparam logic [7:0] MULTI_RST_R2 = 8'h01;
  localparam logic [7:0] ZERO8 = 8'h00;

  localparam int STAT1_SETTLED_BIT = 0;
  localparam int STAT1_HOT_BIT = 1;
  localparam int STAT1_IMAX_BIT = 2;
  localparam int MARGIN_SIGN_BIT = 7;

  localparam int CLK_MHZ = 100;
  localparam int OC_QUAL_US = 120;
  localparam int IMB_QUAL_US = 1000;
  localparam int OC_QUAL_CYC = OC_QUAL_US * CLK_MHZ;
  localparam int IMB_QUAL_CYC = IMB_QUAL_US * CLK_MHZ;
  localparam int DIODE_TARGET_NS = 40;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int DIODE_TARGET_CYC = DIODE_TARGET_NS / CLK_PERIOD_NS;
  localparam int QCNT_W = 24;
  localparam logic [5:0] ZC_THR_RST = 6'h20;

  typedef enum logic [1:0] {
    VRFP_OV_IDLE = 2'b00,
    VRFP_OV_PULL = 2'b01,
    VRFP_OV_OFF = 2'b10
  } vrfp_ov_state_type;

  typedef enum logic [1:0] {
    VRFP_SLEW_NONE = 2'b00,
    VRFP_SLEW_FAST = 2'b01,
    VRFP_SLEW_SLOW = 2'b10,
    VRFP_SLEW_DECAY = 2'b11
  } vrfp_slew_type;

  // analog comparator results, synchronised by the core, which also qualifies oc_above and imbalance_above
  typedef struct packed {
    logic oc_above;
    logic way_oc_above;
    logic imbalance_above;
    logic ov_above;
    logic below_setpoint;
  } vrfp_sense_type;

  typedef struct packed {
    logic high_on;
    logic low_on;
    logic tristate;
  } vrfp_drive_type;
endpackage

// *** verif/vrfp_core_assertions.sv ***
// vrfp_core_checker: checks on the core's ports
`timescale 1ns/1ps
`default_nettype none
module vrfp_core_checker import vrfp_pkg::*; #(
  parameter int OC_QUAL = 20
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic regulator_enable_in,
  input wire vrfp_sense_type sense_in,
  input wire logic discontinuous_mode_in,
  input wire logic zero_cross_in,
  input wire logic reg_write_in,
  input wire logic register_read_command_in,
  input wire logic voltage_set_command_in,
  input wire logic [7:0] reg_index_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic not_supported_out,
  input wire logic power_good_out,
  input wire vrfp_drive_type drive_out,
  input wire logic low_side_end_out,
  input wire logic [5:0] zc_threshold_out,
  input wire logic alert_n_out
);
  // ------
  // limit shadow, overcurrent run
  // ------
  logic [7:0] vmax_r;
  logic [15:0] oc_cnt_r;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      vmax_r <= VMAX_RST;
    end else if (reg_write_in && !voltage_set_command_in && reg_index_in == REG_VMAX) begin
      vmax_r <= reg_wdata_in;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !sense_in.oc_above || !regulator_enable_in) begin
      oc_cnt_r <= 16'h0000;
    end else if (oc_cnt_r != 16'hFFFF) begin
      oc_cnt_r <= oc_cnt_r + 16'h0001;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_read_proto: assert property (
    register_read_command_in && reg_index_in == REG_PROTO |=> reg_rdata_out == PROTO_VAL)
    else $error("bad protocol read");
  a_read_caps: assert property (
    register_read_command_in && reg_index_in == REG_CAPS |=> reg_rdata_out == CAPS_VAL)
    else $error("bad caps read");
  a_refuse_high_code: assert property (
    voltage_set_command_in && reg_wdata_in > vmax_r |=> not_supported_out)
    else $error("high code taken");
  a_accept_low_code: assert property (
    voltage_set_command_in && reg_wdata_in <= vmax_r |=> !not_supported_out)
    else $error("legal code refused");
  a_shadow_copy: assert property (
    (register_read_command_in && reg_index_in == REG_STAT2) ##2
    (register_read_command_in && reg_index_in == REG_STAT2_SHADOW)
    |=> reg_rdata_out == $past(reg_rdata_out, 2))
    else $error("shadow mismatch");
  a_oc_trip: assert property (
    oc_cnt_r == OC_QUAL + 2 |-> ##[0:4] (!power_good_out && drive_out.tristate))
    else $error("overcurrent not latched");
  a_way_oc_fast: assert property (
    (sense_in.way_oc_above && regulator_enable_in)[*3]
    |-> ##[0:3] (!power_good_out && drive_out.tristate))
    else $error("short not shut off");
  a_ov_pull_down: assert property (
    (sense_in.ov_above && !sense_in.below_setpoint && regulator_enable_in)[*4]
    |-> ##[0:3] (drive_out.low_on && !power_good_out))
    else $error("no overvoltage pull");
  a_ov_release: assert property (
    (sense_in.below_setpoint && !sense_in.ov_above)[*6] |-> !drive_out.low_on)
    else $error("low side held");
  a_dcm_end: assert property (
    (discontinuous_mode_in && zero_cross_in)[*5] |-> low_side_end_out)
    else $error("no zero-cross end");
  a_reset_outs: assert property (
    disable iff (1'b0) rst_in |=> (!power_good_out && drive_out.tristate && alert_n_out
    && zc_threshold_out == ZC_THR_RST))
    else $error("bad reset outputs");
  c_refused: cover property (not_supported_out);
  c_pg_drop: cover property ($fell(power_good_out));
  c_pull: cover property (drive_out.low_on);
  c_alert: cover property (!alert_n_out);
endmodule
`default_nettype wire

// *** verif/vrfp_host_model.sv ***
// vrfp_host_model: master issuing register commands
`timescale 1ns/1ps
`default_nettype none
module vrfp_host_model import vrfp_pkg::*; (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic nsup_in,
  output logic wr_out,
  output logic rd_out,
  output logic set_out,
  output logic ps_out,
  output logic [7:0] idx_out,
  output logic [7:0] wdata_out,
  output vrfp_slew_type slew_out
);
  initial begin
    {wr_out, rd_out, set_out, ps_out} = 4'h0;
    idx_out = 8'h00;
    wdata_out = 8'h00;
    slew_out = VRFP_SLEW_NONE;
  end
  // idle bus shows inverted values
  task automatic pulse(input logic [3:0] cmd, input logic [7:0] i, input logic [7:0] d,
      input vrfp_slew_type sl);
    @(negedge clk_in);
    {wr_out, rd_out, set_out, ps_out} = cmd;
    idx_out = i;
    wdata_out = d;
    slew_out = sl;
    @(negedge clk_in);
    {wr_out, rd_out, set_out, ps_out} = 4'h0;
    idx_out = ~i;
    wdata_out = ~d;
  endtask
  task automatic do_read(input logic [7:0] i, output logic [7:0] d);
    pulse(4'h4, i, 8'h00, VRFP_SLEW_NONE);
    d = rdata_in;
  endtask
  task automatic do_write(input logic [7:0] i, input logic [7:0] d);
    pulse(4'h8, i, d, VRFP_SLEW_NONE);
  endtask
  task automatic do_set(input logic [7:0] d, input vrfp_slew_type sl, output logic refused);
    pulse(4'h2, 8'h00, d, sl);
    refused = nsup_in;
  endtask
  task automatic do_pstate(input logic [7:0] d);
    pulse(4'h1, 8'h00, d, VRFP_SLEW_NONE);
  endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// tb_top: directed bench for the fault and register core
`timescale 1ns/1ps
`default_nettype none
module tb_top import vrfp_pkg::*; ();
  localparam int OCQ = 20;
  localparam int IMQ = 50;
  int fails = 0;
  int n_compared = 0;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic regulator_enable_in = 1'b1;
  vrfp_sense_type sense_in = '0;
  logic discontinuous_mode_in = 1'b0, zero_cross_in = 1'b0;
  logic phase_node_neg_in = 1'b0, low_side_done_in = 1'b0;
  logic [7:0] strap_imax_in = 8'h64;
  logic [7:0] strap_tmax_in = 8'h5F;
  logic [7:0] strap_boot_in = 8'h30;
  logic target_reached_in = 1'b0, hot_in = 1'b0, imax_reached_in = 1'b0;
  logic [7:0] tzone_in = 8'h3F;
  logic [7:0] secondary_status_in = 8'h00;
  logic reg_write_in, register_read_command_in, voltage_set_command_in, power_state_write_in;
  logic [7:0] reg_index_in, reg_wdata_in, reg_rdata_out, target_code_out;
  vrfp_slew_type slew_in;
  logic not_supported_out, power_good_out, low_side_end_out, soft_start_out, alert_n_out;
  vrfp_drive_type drive_out;
  logic [5:0] zc_threshold_out;
  always #5 core_clk_in = ~core_clk_in;
  vrfp_core #(.OC_QUAL(OCQ), .IMB_QUAL(IMQ)) DUT (.*);
  vrfp_host_model host (.clk_in(core_clk_in), .rdata_in(reg_rdata_out),
    .nsup_in(not_supported_out), .wr_out(reg_write_in), .rd_out(register_read_command_in),
    .set_out(voltage_set_command_in), .ps_out(power_state_write_in), .idx_out(reg_index_in),
    .wdata_out(reg_wdata_in), .slew_out(slew_in));
  // ------
  // shared helpers
  // ------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    logic [7:0] d;
    host.do_read(i, d);
    check(d, exp, "register read");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic wait_pg(input logic lvl, input int lim);
    for (int k = 0; k < lim; k++) begin
      if (power_good_out === lvl) break;
      cyc(1);
    end
    check({7'h00, power_good_out}, {7'h00, lvl}, "power good");
  endtask
  task automatic restart();
    logic seen;
    seen = 1'b0;
    sense_in = '0;
    regulator_enable_in = 1'b0;
    cyc(4);
    regulator_enable_in = 1'b1;
    repeat (8) begin
      cyc(1);
      seen = seen | soft_start_out;
    end
    check({7'h00, seen}, 8'h01, "soft start");
    wait_pg(1'b1, 60);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_regs();
    logic [7:0] idx [12] = '{REG_PROTO, REG_CAPS, REG_FAST_SLEW_RATE, REG_SLOW_SLEW_RATE, REG_VMAX, REG_VSET,
      REG_PSTATE, REG_MARGIN, REG_MULTI, REG_IMAX, REG_TMAX, 8'h07};
    logic [7:0] exp [12] = '{PROTO_VAL, CAPS_VAL, FAST_SLEW_RATE_VAL, SLOW_SLEW_RATE_VAL, VMAX_RST, ZERO8,
      ZERO8, ZERO8, MULTI_RST_R1, 8'h64, 8'h5F, ZERO8};
    for (int k = 0; k < 12; k++) rd(idx[k], exp[k]);
    check(target_code_out, 8'h30, "boot target");
    host.do_write(REG_PROTO, 8'h55);
    rd(REG_PROTO, PROTO_VAL);
    rd(REG_TZONE, 8'h3F);
  endtask
  task automatic t_set();
    logic r;
    host.do_write(REG_VMAX, 8'h80);
    host.do_set(8'h81, VRFP_SLEW_FAST, r);
    check({7'h00, r}, 8'h01, "refused flag");
    rd(REG_VSET, ZERO8);
    host.do_set(8'h80, VRFP_SLEW_FAST, r);
    check({7'h00, r}, 8'h00, "accepted flag");
    rd(REG_VSET, 8'h80);
    host.do_write(REG_MARGIN, 8'h83);
    cyc(2);
    check(target_code_out, 8'h7D, "negative margin");
    host.do_write(REG_MARGIN, 8'h03);
    cyc(2);
    check(target_code_out, 8'h83, "positive margin");
    host.do_pstate(8'h02);
    rd(REG_PSTATE, 8'h02);
  endtask
  task automatic t_alert();
    target_reached_in = 1'b1;
    hot_in = 1'b1;
    cyc(5);
    check({7'h00, alert_n_out}, 8'h00, "alert asserted");
    rd(REG_STAT1, 8'h03);
    check({7'h00, alert_n_out}, 8'h01, "alert cleared");
    hot_in = 1'b0;
  endtask
  task automatic t_shadow();
    secondary_status_in = 8'h5A;
    rd(REG_STAT2, 8'h5A);
    rd(REG_STAT2_SHADOW, 8'h5A);
    secondary_status_in = 8'h3C;
    rd(REG_STAT2_SHADOW, 8'h5A);
  endtask
  task automatic diode(input int n, input logic [7:0] exp);
    low_side_done_in = 1'b1;
    cyc(1);
    low_side_done_in = 1'b0;
    phase_node_neg_in = 1'b1;
    cyc(n);
    phase_node_neg_in = 1'b0;
    cyc(8);
    check({2'b00, zc_threshold_out}, exp, "threshold step");
  endtask
  task automatic t_dcm();
    discontinuous_mode_in = 1'b1;
    zero_cross_in = 1'b1;
    cyc(4);
    check({7'h00, low_side_end_out}, 8'h01, "low side end");
    zero_cross_in = 1'b0;
    cyc(4);
    check({7'h00, low_side_end_out}, 8'h00, "low side kept");
    diode(10, 8'h21);
    diode(2, 8'h20);
  endtask
  task automatic t_oc();
    restart();
    repeat (2) begin
      sense_in.oc_above = 1'b1;
      cyc(OCQ - 4);
      sense_in.oc_above = 1'b0;
      cyc(1);
    end
    cyc(4);
    check({7'h00, power_good_out}, 8'h01, "broken runs");
    sense_in.oc_above = 1'b1;
    wait_pg(1'b0, OCQ + 8);
    check({5'h00, drive_out}, 8'h01, "drives off");
    sense_in.oc_above = 1'b0;
    cyc(6);
    check({7'h00, power_good_out}, 8'h00, "fault latched");
  endtask
  task automatic t_fast_faults();
    restart();
    sense_in.way_oc_above = 1'b1;
    cyc(5);
    check({4'h0, drive_out, power_good_out}, 8'h02, "short shut off");
    restart();
    sense_in.imbalance_above = 1'b1;
    cyc(IMQ - 4);
    check({7'h00, power_good_out}, 8'h01, "imbalance early");
    wait_pg(1'b0, 12);
    check({5'h00, drive_out}, 8'h01, "imbalance drives off");
  endtask
  task automatic t_ov();
    restart();
    sense_in.ov_above = 1'b1;
    cyc(5);
    check({6'h00, drive_out.low_on, power_good_out}, 8'h02, "pull down");
    sense_in.ov_above = 1'b0;
    cyc(5);
    check({7'h00, drive_out.low_on}, 8'h01, "pull held");
    sense_in.below_setpoint = 1'b1;
    cyc(6);
    check({6'h00, drive_out.low_on, drive_out.tristate}, 8'h01, "pull released");
    sense_in.below_setpoint = 1'b0;
    sense_in.ov_above = 1'b1;
    cyc(5);
    check({7'h00, drive_out.low_on}, 8'h01, "pull repeated");
    sense_in.ov_above = 1'b0;
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    cyc(8);
    rst_in = 1'b0;
    cyc(4);
    t_regs();
    t_set();
    t_alert();
    t_shadow();
    t_dcm();
    t_oc();
    t_fast_faults();
    t_ov();
    give_verdict();
  end
  // hang guard
  initial begin
    #200000;
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
bind vrfp_core vrfp_core_checker #(.OC_QUAL(OC_QUAL)) chk (.*);
`default_nettype wire
